// ### hw/arpt_timer.sv
// Auto-reload PWM / capture timer with APB register access.
// Assumes timer_input_pin is already synchronous-safe to sample twice
// and that the APB master keeps the usual setup/access protocol.
//
// Notes on behaviour
// - Counter is 8-bit, counts up on each prescaler output tick.
// - No direct counter access; load register reads and writes live count.
// - Prescaler source: internal clock, internal clock /3, or input pin.
// - 7-bit prescaler, eight taps, divide by 2 to the power n.
// - Gate clear freezes prescaler and counter; set lets them run.
// - System reset clears the counter to zero.
// - Load register write copies value into counter at once, running or not.
// - Every counter load also clears the prescaler.
// - Overflow reloads from reload value and drives PWM high.
// - Count equal to compare drives PWM low and sets compare flag.
// - Overflow sets overflow flag, requests interrupt if enabled; software clears.
// - Compare match requests interrupt if enabled; software clears flag.
// - Capture modes copy count to reload register, set edge flag.
// - Capture-with-reset mode also clears counter and prescaler.
// - External-load mode: active edge loads reload value into counter.
// - Second request during service stays latched until presented.
// - Mode field: 00 reload, 01 capture, 10 capture-reset, 11 ext load.
// - Edge enable off disables detection; polarity 0 rising, 1 falling.
// - Writing zero clears a flag; writing one leaves it.
// - Clock select: 00 internal, 01 divided by three, 10 pin, 11 none.
`timescale 1ns/1ps
module arpt_timer #(
	parameter int ADDR_W = 12
) (
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              timer_input_pin,
	output logic                   pwm_output_pin,
	output logic                   irq_req
);
	import arpt_pkg::*;

	// Byte address of a register index
	function automatic logic [ADDR_W-1:0] reg_addr(input logic [7:0] idx);
		reg_addr = ADDR_W'({idx, 2'b00});
	endfunction : reg_addr

	// Low-bit mask that selects prescaler tap n
	function automatic logic [6:0] tap_mask(input logic [2:0] n);
		tap_mask = PSC_FULL >> (TAP_TOP - n);
	endfunction : tap_mask

	////////////////////////////////////////////////////////////////////////
	// State
	logic [6:0]  mode_ctl_q;
	logic [7:0]  cfg_q;
	logic [2:0]  flags_q, flags_d;
	logic [7:0]  reload_q, reload_d;
	logic [7:0]  cmp_q;
	logic [7:0]  cnt_q, cnt_d;
	logic [6:0]  psc_q, psc_d;
	logic [1:0]  div3_q;
	logic        sync1_q, sync2_q, pin_prev_q;
	logic        cnt_chg_q;
	logic        pwm_q, pwm_d;
	logic [31:0] prdata_q, rdata;
	logic        pready_q, pslverr_q, pwm_pin_q, irq_q;

	////////////////////////////////////////////////////////////////////////
	// APB decode; zero wait states, answer in the access cycle
	wire setup   = psel & ~penable;
	wire acc     = psel & penable & pready_q;
	wire hit_mc  = paddr == reg_addr(IDX_MODE);
	wire hit_fl  = paddr == reg_addr(IDX_FLAGS);
	wire hit_cf  = paddr == reg_addr(IDX_CFG);
	wire hit_rl  = paddr == reg_addr(IDX_RELOAD);
	wire hit_cp  = paddr == reg_addr(IDX_CMP);
	wire hit_ot  = paddr == reg_addr(IDX_OTF);
	wire hit     = hit_mc | hit_fl | hit_cf | hit_rl | hit_cp | hit_ot;
	wire wr      = acc & pwrite;
	wire wr_mc   = wr & hit_mc;
	wire wr_fl   = wr & hit_fl;
	wire wr_cf   = wr & hit_cf;
	wire wr_rl   = wr & hit_rl;
	wire wr_cp   = wr & hit_cp;
	wire otf_wr  = wr & hit_ot;
	wire strobe  = wr_mc & pwdata[MC_LOAD];

	// Read mux; load strobe reads zero, load register shows live count
	always_comb begin
		rdata = 32'h0000_0000;
		if (hit_mc) begin
			rdata[6:0] = mode_ctl_q;
		end else if (hit_fl) begin
			rdata[2:0] = flags_q;
		end else if (hit_cf) begin
			rdata[7:0] = cfg_q;
		end else if (hit_rl) begin
			rdata[7:0] = reload_q;
		end else if (hit_cp) begin
			rdata[7:0] = cmp_q;
		end else if (hit_ot) begin
			rdata[7:0] = cnt_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field views
	wire             gate    = mode_ctl_q[MC_GATE];
	wire arpt_mode_t mode    = arpt_mode_t'(mode_ctl_q[1:0]);
	wire arpt_clk_t  clk_sel = arpt_clk_t'(cfg_q[1:0]);
	wire [2:0]       tap     = cfg_q[CF_TAP_LSB +: 3];
	wire [2:0]       en_mask = {mode_ctl_q[MC_EIE], mode_ctl_q[MC_COMPARE_IRQ_ENABLE],
		mode_ctl_q[MC_OVERFLOW_IRQ_ENABLE]};

	// Edge detect on the synchronised pin; first stage feeds only the second
	wire pin_rise = sync2_q & ~pin_prev_q;
	wire pin_fall = ~sync2_q & pin_prev_q;
	wire edge_evt = cfg_q[CF_EDGE_EN] &
		(cfg_q[CF_POL] ? pin_fall : pin_rise);

	// Prescaler source enable
	wire src_en = (clk_sel == CLK_INT)  ? 1'b1 :
		(clk_sel == CLK_DIV3) ? (div3_q == DIV3_LAST) :
		(clk_sel == CLK_PIN)  ? pin_rise : 1'b0;

	// Counter tick from the selected prescaler tap
	wire tick = gate & src_en &
		((psc_q & tap_mask(tap)) == tap_mask(tap));

	// Mode events
	wire cap_evt  = edge_evt &
		(mode == MODE_CAPTURE || mode == MODE_CAP_RST);
	wire cap_rst  = edge_evt & (mode == MODE_CAP_RST);
	wire ext_load = edge_evt & (mode == MODE_EXT_LOAD);
	wire hi_load  = otf_wr | strobe | cap_rst | ext_load;
	wire ovf_evt  = tick & (cnt_q == CNT_MAX) & ~hi_load;
	wire any_load = hi_load | ovf_evt;
	wire cmp_evt  = cnt_chg_q & (cnt_q == cmp_q);
	wire [2:0] set_vec = {edge_evt, cmp_evt, ovf_evt};

	// Counter next value, highest priority first
	always_comb begin
		if (otf_wr) begin
			cnt_d = pwdata[7:0];
		end else if (strobe) begin
			cnt_d = reload_q;
		end else if (cap_rst) begin
			cnt_d = BYTE_ZERO;
		end else if (ext_load) begin
			cnt_d = reload_q;
		end else if (ovf_evt) begin
			cnt_d = reload_q;
		end else if (tick) begin
			cnt_d = cnt_q + 8'h01;
		end else begin
			cnt_d = cnt_q;
		end
	end

	// Prescaler next value; cleared on any load, frozen when gated off
	always_comb begin
		if (any_load) begin
			psc_d = PSC_ZERO;
		end else if (gate & src_en) begin
			psc_d = psc_q + 7'h01;
		end else begin
			psc_d = psc_q;
		end
	end

	// Capture wins over a software write in the same cycle
	assign reload_d = cap_evt ? cnt_q : (wr_rl ? pwdata[7:0] : reload_q);

	// Hardware set wins over software clear; writing one keeps the flag
	assign flags_d = ((wr_fl ? (flags_q & pwdata[2:0]) : flags_q) |
		set_vec);

	// Compare clears the output, overflow sets it
	assign pwm_d = cmp_evt ? 1'b0 : (ovf_evt ? 1'b1 : pwm_q);

	////////////////////////////////////////////////////////////////////////
	// Registers written by software
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			mode_ctl_q <= 7'h00;
			cfg_q      <= BYTE_ZERO;
			cmp_q      <= BYTE_ZERO;
		end else begin
			if (wr_mc) mode_ctl_q <= pwdata[6:0];
			if (wr_cf) cfg_q <= pwdata[7:0];
			if (wr_cp) cmp_q <= pwdata[7:0];
		end
	end

	// Timer core state
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q     <= BYTE_ZERO;
			psc_q     <= PSC_ZERO;
			reload_q  <= BYTE_ZERO;
			flags_q   <= 3'h0;
			pwm_q     <= 1'b0;
			cnt_chg_q <= 1'b0;
		end else begin
			cnt_q     <= cnt_d;
			psc_q     <= psc_d;
			reload_q  <= reload_d;
			flags_q   <= flags_d;
			pwm_q     <= pwm_d;
			cnt_chg_q <= tick | any_load;
		end
	end

	// Divide-by-three enable and pin synchroniser
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			div3_q     <= DIV3_ZERO;
			sync1_q    <= 1'b0;
			sync2_q    <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			div3_q     <= (div3_q == DIV3_LAST) ? DIV3_ZERO : div3_q + 2'h1;
			sync1_q    <= timer_input_pin;
			sync2_q    <= sync1_q;
			pin_prev_q <= sync2_q;
		end
	end

	// Bus answer and pin outputs, all from flops
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			pwm_pin_q <= 1'b0;
			irq_q     <= 1'b0;
		end else begin
			if (setup) prdata_q <= rdata;
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			pwm_pin_q <= mode_ctl_q[MC_PWMOE] & pwm_d;
			irq_q     <= |(flags_d & en_mask);
		end
	end

	assign prdata         = prdata_q;
	assign pready         = pready_q;
	assign pslverr        = pslverr_q;
	assign pwm_output_pin = pwm_pin_q;
	assign irq_req        = irq_q;

	////////////////////////////////////////////////////////////////////////
	// Assertions
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_count_step: assert property (tick && !any_load |=>
		cnt_q == $past(cnt_q) + 8'h01)
		else $error("counter did not step by one");

	a_gate_hold: assert property (!gate && !hi_load |=>
		$stable(cnt_q) && $stable(psc_q))
		else $error("counter or prescaler moved while gated");

	a_otf_load: assert property (otf_wr |=>
		cnt_q == $past(pwdata[7:0]) && psc_q == PSC_ZERO)
		else $error("load register write not copied");

	a_ovf_reload: assert property (ovf_evt |=>
		cnt_q == $past(reload_q) && flags_q[FL_OVF] && psc_q == PSC_ZERO)
		else $error("overflow reload or flag wrong");

	a_cmp_low: assert property (cmp_evt |=>
		!pwm_q && flags_q[FL_CPF] && !pwm_pin_q)
		else $error("compare did not clear output");

	a_ovf_irq: assert property (ovf_evt && mode_ctl_q[MC_OVERFLOW_IRQ_ENABLE] |=>
		irq_q)
		else $error("overflow interrupt not raised");

	a_capture_copy: assert property (cap_evt |=>
		reload_q == $past(cnt_q) && flags_q[FL_EF])
		else $error("capture value or edge flag wrong");

	a_cap_reset: assert property (cap_rst && !otf_wr && !strobe |=>
		cnt_q == BYTE_ZERO && psc_q == PSC_ZERO)
		else $error("capture reset not applied");

	a_ext_load: assert property (ext_load && !otf_wr && !strobe |=>
		cnt_q == $past(reload_q))
		else $error("external load not applied");

	a_flag_clear: assert property (wr_fl && !pwdata[FL_OVF] && !ovf_evt
		|=> !flags_q[FL_OVF])
		else $error("overflow flag not cleared");

	a_pin_edge: assert property ($rose(sync1_q) && cfg_q[CF_EDGE_EN] &&
		!cfg_q[CF_POL] && $stable(cfg_q) && !wr_cf |=> edge_evt)
		else $error("rising edge not detected");

	c_pwm_cycle: cover property (ovf_evt ##[1:300] cmp_evt);
	c_capture:   cover property (cap_rst ##[1:300] cap_rst);
	c_set_clear: cover property (wr_fl && ovf_evt);

endmodule : arpt_timer

// ### hw/arpt_pkg.sv
// Package for the auto-reload PWM / capture timer.
// Assumes one system clock; registers reached over a 32-bit APB slave.
package arpt_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_MODE   = 8'hd5;
	localparam logic [7:0] IDX_FLAGS  = 8'hd6;
	localparam logic [7:0] IDX_CFG    = 8'hd7;
	localparam logic [7:0] IDX_RELOAD = 8'hd9;
	localparam logic [7:0] IDX_CMP    = 8'hda;
	localparam logic [7:0] IDX_OTF    = 8'hdb;

	// mode_control fields
	localparam int MC_LOAD  = 7;
	localparam int MC_GATE  = 6;
	localparam int MC_PWMOE = 5;
	localparam int MC_EIE   = 4;
	localparam int MC_COMPARE_IRQ_ENABLE  = 3;
	localparam int MC_OVERFLOW_IRQ_ENABLE  = 2;

	// clock_edge_config fields
	localparam int CF_TAP_LSB = 5;
	localparam int CF_POL     = 3;
	localparam int CF_EDGE_EN = 2;

	// event_flags fields
	localparam int FL_EF  = 2;
	localparam int FL_CPF = 1;
	localparam int FL_OVF = 0;

	// Values
	localparam logic [7:0] CNT_MAX   = 8'hff;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	localparam logic [6:0] PSC_ZERO  = 7'h00;
	localparam logic [6:0] PSC_FULL  = 7'h7f;
	localparam logic [2:0] TAP_TOP   = 3'h7;
	localparam logic [1:0] DIV3_LAST = 2'h2;
	localparam logic [1:0] DIV3_ZERO = 2'h0;

	typedef enum logic [1:0] {
		MODE_RELOAD   = 2'b00,
		MODE_CAPTURE  = 2'b01,
		MODE_CAP_RST  = 2'b10,
		MODE_EXT_LOAD = 2'b11
	} arpt_mode_t;

	typedef enum logic [1:0] {
		CLK_INT  = 2'b00,
		CLK_DIV3 = 2'b01,
		CLK_PIN  = 2'b10,
		CLK_RSV  = 2'b11
	} arpt_clk_t;

endpackage : arpt_pkg

// ### tb/arpt_pin_drv.sv
// Model of the external source that drives timer_input_pin.
// Assumes a one-cycle fire request, sampled on ref_clk.
`timescale 1ns/1ps
module arpt_pin_drv (
	input  wire logic ref_clk,
	input  wire logic rst,
	input  wire logic fire,
	output logic      timer_input_pin
);
	logic [2:0] cnt_q;

	////////////////////////////////////////////////////////////////////////
	// Pulse four clocks high, then stay low until fired again
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
		end else if (fire) begin
			cnt_q <= 3'h4;
		end else if (cnt_q != 3'h0) begin
			cnt_q <= cnt_q - 3'h1;
		end
	end

	// Pin level follows the pulse counter
	assign timer_input_pin = (cnt_q != 3'h0);
endmodule : arpt_pin_drv

// ### tb/test_arpt_timer.sv
// Self-checking bench for the auto-reload PWM / capture timer.
// Assumes zero-wait APB answers and the pin model beside the design.
`timescale 1ns/1ps
module test_arpt_timer;
	import arpt_pkg::*;
	logic        ref_clk, rst, psel, penable, pwrite, fire;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic        pready, pslverr, rerr, pin, pwm, irq;
	int          err_count, num_checks, cyc, hi;
	localparam logic [7:0] REGS [6] = '{IDX_MODE, IDX_FLAGS, IDX_CFG,
		IDX_RELOAD, IDX_CMP, IDX_OTF};

	arpt_timer arpt_timer_inst (.ref_clk(ref_clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.timer_input_pin(pin), .pwm_output_pin(pwm), .irq_req(irq));
	arpt_pin_drv arpt_pin_drv_inst (.ref_clk(ref_clk), .rst(rst),
		.fire(fire), .timer_input_pin(pin));

	////////////////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] idx,
		input logic [31:0] d);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'h0, idx, 2'h0};
		pwdata  <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1) @(posedge ref_clk);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic pulse();
		@(posedge ref_clk);
		fire <= 1'b1;
		@(posedge ref_clk);
		fire <= 1'b0;
		repeat (10) @(posedge ref_clk);
	endtask : pulse

	// Load zero, run the gate for a span, stop, read the count
	task automatic span(input logic [7:0] c, input int w);
		apb(1'b1, IDX_OTF, 32'h0);
		apb(1'b1, IDX_CFG, {24'h0, c});
		apb(1'b1, IDX_MODE, 32'h40);
		repeat (w) @(posedge ref_clk);
		apb(1'b1, IDX_MODE, 32'h0);
		apb(1'b0, IDX_OTF, 32'h0);
	endtask : span

	// One edge event with the counter frozen at a known value
	task automatic cap(input logic [1:0] m, input logic [7:0] c, o, er, eo,
		input logic ef);
		apb(1'b1, IDX_MODE, {24'h0, 3'h0, 1'b1, 2'h0, m});
		apb(1'b1, IDX_CFG, {24'h0, c});
		apb(1'b1, IDX_RELOAD, 32'h77);
		apb(1'b1, IDX_OTF, {24'h0, o});
		pulse();
		apb(1'b0, IDX_RELOAD, 32'h0);
		chk("capture reg", rdat, {24'h0, er});
		apb(1'b0, IDX_OTF, 32'h0);
		chk("count", rdat, {24'h0, eo});
		apb(1'b0, IDX_FLAGS, 32'h0);
		chk("edge flag", rdat, {29'h0, ef, 2'h0});
		chk("edge irq", {31'h0, irq}, {31'h0, ef});
		apb(1'b1, IDX_FLAGS, 32'h0);
	endtask : cap

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		{psel, penable, pwrite, fire} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		rst = 1'b1;
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			apb(1'b0, REGS[i], 32'h0);
			chk("reset value", rdat, 32'h0);
		end
		apb(1'b0, 8'h00, 32'h0);
		chk("unmapped", {31'h0, rerr}, 32'h1);
		apb(1'b1, IDX_OTF, 32'ha5);
		apb(1'b0, IDX_OTF, 32'h0);
		chk("load reg", rdat, 32'ha5);
		apb(1'b1, IDX_RELOAD, 32'h99);
		apb(1'b1, IDX_MODE, 32'h80);
		apb(1'b0, IDX_OTF, 32'h0);
		chk("load strobe", rdat, 32'h99);
		apb(1'b0, IDX_MODE, 32'h0);
		chk("strobe reads 0", rdat, 32'h0);
		// Spans end one cycle past mid-way between ticks, so one cycle less is safe
		for (int n = 2; n < 8; n++) begin
			span({n[2:0], 5'h00}, ((7 << n) / 2) - 2);
			chk("tap count", rdat, 32'h3);
		end
		repeat (20) @(posedge ref_clk);
		apb(1'b0, IDX_OTF, 32'h0);
		chk("frozen", rdat, 32'h3);
		span(8'h03, 60);
		chk("no source", rdat, 32'h0);
		// Divide-by-three source: 30 gated cycles give ten ticks
		span(8'h01, 27);
		chk("div3 count", rdat, 32'ha);
		apb(1'b1, IDX_OTF, 32'h0);
		apb(1'b1, IDX_CFG, 32'h02);
		apb(1'b1, IDX_MODE, 32'h40);
		repeat (3) pulse();
		apb(1'b1, IDX_MODE, 32'h0);
		apb(1'b0, IDX_OTF, 32'h0);
		chk("pin clock", rdat, 32'h3);
		// Compare parked where no capture count lands; stale flags cleared
		apb(1'b1, IDX_CMP, 32'hfe);
		apb(1'b1, IDX_FLAGS, 32'h0);
		cap(2'b01, 8'h04, 8'h20, 8'h20, 8'h20, 1'b1);
		cap(2'b01, 8'h0c, 8'h30, 8'h30, 8'h30, 1'b1);
		cap(2'b01, 8'h08, 8'h40, 8'h77, 8'h40, 1'b0);
		cap(2'b10, 8'h04, 8'h50, 8'h50, 8'h00, 1'b1);
		cap(2'b11, 8'h04, 8'h11, 8'h77, 8'h77, 1'b1);
		// PWM: high from reload to one cycle past the compare match
		apb(1'b1, IDX_CFG, 32'h0);
		apb(1'b1, IDX_RELOAD, 32'hf0);
		apb(1'b1, IDX_CMP, 32'hf8);
		apb(1'b1, IDX_MODE, 32'he4);
		repeat (24) @(posedge ref_clk);
		hi = 0;
		repeat (64) begin
			@(posedge ref_clk);
			hi += (pwm === 1'b1);
		end
		chk("pwm high", hi, 36);
		apb(1'b1, IDX_MODE, 32'h24);
		apb(1'b0, IDX_FLAGS, 32'h0);
		chk("flags", rdat, 32'h3);
		chk("ovf irq", {31'h0, irq}, 32'h1);
		apb(1'b1, IDX_FLAGS, 32'h06);
		apb(1'b0, IDX_FLAGS, 32'h0);
		chk("ovf cleared", rdat, 32'h2);
		chk("irq dropped", {31'h0, irq}, 32'h0);
		print_verdict();
	end
endmodule : test_arpt_timer
